// ==== rtl/ebc_defs.svh ====
// Constants for the EPROM burn and bootload control block
`ifndef EBC_DEFS_SVH
`define EBC_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define EBC_OFS_BURN 4'h0
`define EBC_OFS_STAT 4'h4
`define EBC_OFS_LAMP 4'h8

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define EBC_BIT_VOLT 0
`define EBC_BIT_LATCH 2
`define EBC_BURN_RST 8'h00
`define EBC_LAMP_RST 2'h0

// ----------------------------------------
// Address ranges
// ----------------------------------------
`define EBC_BOOT_LO 14'h3f00
`define EBC_BOOT_HI 14'h3fef
`define EBC_EPROM_LO 14'h0020
`define EBC_EPROM_HI 14'h3eff

// ----------------------------------------
// Timing
// ----------------------------------------
`define EBC_CLK_MHZ 50
`define EBC_BURN_PULSE_US 4000
`define EBC_BURN_PULSE_CYC (`EBC_BURN_PULSE_US * `EBC_CLK_MHZ)

`endif

// ==== rtl/ebc_pkg.sv ====
// Types for the EPROM burn and bootload control block
package ebc_pkg;

    // Loader function decoded from the select pins
    typedef enum logic [2:0] {
        EBC_FN_BURN_CHECK = 3'h0,
        EBC_FN_CHECK_ONLY = 3'h1,
        EBC_FN_LOAD_RUN = 3'h2,
        EBC_FN_NONE = 3'h3,
        EBC_FN_SECURE = 3'h4
    } ebc_func_type;

    // Burn sequence, Gray coded along the normal path
    typedef enum logic [1:0] {
        EBC_ST_IDLE = 2'h0,
        EBC_ST_ARMED = 2'h1,
        EBC_ST_HELD = 2'h3,
        EBC_ST_BURN = 2'h2
    } ebc_state_type;

endpackage

// ==== rtl/ebc_pulse_timer.sv ====
// Burn pulse timer: flags when the voltage has been held long enough
`timescale 1ns/1ps

module ebc_pulse_timer #(
    parameter int CYCLES = 200000
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control and result
    input wire logic run_i,
    output logic done_o
);

    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] count_reg;
    logic done_reg;

    // Count while running, restart when stopped
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_i)
        begin
            count_reg <= '0;
        end
        else if (count_reg != CW'(CYCLES))
        begin
            count_reg <= count_reg + CW'(1);
        end
    end

    // Done once the full count is reached
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !run_i)
        begin
            done_reg <= 1'b0;
        end
        else
        begin
            done_reg <= (count_reg == CW'(CYCLES - 1)) || done_reg;
        end
    end

    assign done_o = done_reg;

endmodule

// ==== rtl/ebc_burn_ctl.sv ====
// EPROM burn control with bootloader mode entry, Wishbone registers
`timescale 1ns/1ps
`include "ebc_defs.svh"

module ebc_burn_ctl #(
    parameter int BURN_PULSE_CYC = `EBC_BURN_PULSE_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Mode entry pins
    input wire logic test_voltage_level_i,
    input wire logic capture_input_pin_i,
    // Function select pins
    input wire logic func_select_hi_i,
    input wire logic func_select_mid_i,
    input wire logic func_select_lo_i,
    // Indicator lamps
    output logic burn_indicator_pin_o,
    output logic check_indicator_pin_o,
    // CPU memory port
    input wire logic [13:0] cpu_adr_i,
    input wire logic cpu_rd_i,
    input wire logic cpu_wr_i,
    input wire logic [7:0] cpu_wdat_i,
    output logic [7:0] cpu_rdat_o,
    output logic boot_rom_sel_o,
    // EPROM array port
    output logic [13:0] arr_adr_o,
    output logic [7:0] arr_wdat_o,
    output logic arr_rd_en_o,
    output logic arr_vpp_o,
    input wire logic [7:0] arr_rdat_i,
    // External image source
    output logic [13:0] ext_adr_o,
    output logic ext_rd_o,
    input wire logic [7:0] ext_rdat_i
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic rst_d_reg;
    logic boot_mode_reg;
    ebc_pkg::ebc_func_type func_reg;
    ebc_pkg::ebc_func_type func_next;
    logic latch_reg;
    logic latch_next;
    logic volt_reg;
    logic volt_next;
    logic captured_reg;
    logic [1:0] lamp_reg;
    ebc_pkg::ebc_state_type state_reg;
    ebc_pkg::ebc_state_type state_next;
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic [7:0] cpu_rdat_reg;
    logic boot_sel_reg;
    logic [13:0] arr_adr_reg;
    logic [7:0] arr_wdat_reg;
    logic rd_en_reg;
    logic [13:0] ext_adr_reg;
    logic ext_rd_reg;
    logic burn_lamp_reg;
    logic check_lamp_reg;
    logic pulse_done;
    logic wb_req;
    logic wb_wr;
    logic wr_burn;
    logic wr_lamp;
    logic in_eprom;
    logic in_boot;

    // ----------------------------------------
    // Decodes
    // ----------------------------------------

    // New request, acked once
    assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wb_wr = wb_req && wb_we_i;
    assign wr_burn = wb_wr && wb_sel_i[0] && (wb_adr_i == `EBC_OFS_BURN);
    assign wr_lamp = wb_wr && wb_sel_i[0] && (wb_adr_i == `EBC_OFS_LAMP);

    // Address windows
    assign in_eprom = (cpu_adr_i >= `EBC_EPROM_LO) && (cpu_adr_i <= `EBC_EPROM_HI);
    assign in_boot = (cpu_adr_i >= `EBC_BOOT_LO) && (cpu_adr_i <= `EBC_BOOT_HI);

    // ----------------------------------------
    // Mode entry
    // ----------------------------------------

    // Reset release detector
    always_ff @(posedge clk_i)
    begin
        rst_d_reg <= rst_i;
    end

    // Mode sampled at the first edge after reset release
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            boot_mode_reg <= 1'b0;
        end
        else if (rst_d_reg)
        begin
            boot_mode_reg <= test_voltage_level_i && capture_input_pin_i;
        end
    end

    // ----------------------------------------
    // Function select
    // ----------------------------------------

    // Pin pattern to loader function
    always_comb
    begin
        if (func_select_hi_i)
        begin
            func_next = ebc_pkg::EBC_FN_SECURE;
        end
        else
        begin
            unique case ({func_select_mid_i, func_select_lo_i})
                2'h0: func_next = ebc_pkg::EBC_FN_BURN_CHECK;
                2'h1: func_next = ebc_pkg::EBC_FN_CHECK_ONLY;
                2'h2: func_next = ebc_pkg::EBC_FN_LOAD_RUN;
                2'h3: func_next = ebc_pkg::EBC_FN_NONE;
            endcase
        end
    end

    // Function register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            func_reg <= ebc_pkg::EBC_FN_NONE;
        end
        else
        begin
            func_reg <= func_next;
        end
    end

    // ----------------------------------------
    // Burn control bits
    // ----------------------------------------

    // Next latch and voltage values
    always_comb
    begin
        latch_next = latch_reg;
        volt_next = volt_reg;
        if (wr_burn)
        begin
            latch_next = wb_dat_i[`EBC_BIT_LATCH];
            // Voltage needs latch set before and kept by this write
            volt_next = wb_dat_i[`EBC_BIT_VOLT] && latch_reg
                && wb_dat_i[`EBC_BIT_LATCH];
        end
    end

    // Latch and voltage registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            latch_reg <= 1'(`EBC_BURN_RST >> `EBC_BIT_LATCH);
            volt_reg <= 1'(`EBC_BURN_RST >> `EBC_BIT_VOLT);
        end
        else
        begin
            latch_reg <= latch_next;
            volt_reg <= volt_next;
        end
    end

    // Programming voltage follows the voltage bit
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            arr_vpp_o <= 1'b0;
        end
        else
        begin
            arr_vpp_o <= volt_next;
        end
    end

    // ----------------------------------------
    // Array address and data paths
    // ----------------------------------------

    // Read enable off while latched
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rd_en_reg <= 1'b1;
        end
        else
        begin
            rd_en_reg <= !latch_next;
        end
    end

    // Capture the first EPROM write after latch set
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !latch_reg)
        begin
            captured_reg <= 1'b0;
        end
        else if (cpu_wr_i && in_eprom)
        begin
            captured_reg <= 1'b1;
        end
    end

    // Address follows the CPU unless latched
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            arr_adr_reg <= '0;
            arr_wdat_reg <= '0;
        end
        else if (!latch_reg)
        begin
            arr_adr_reg <= cpu_adr_i;
        end
        else if (!captured_reg && cpu_wr_i && in_eprom)
        begin
            arr_adr_reg <= cpu_adr_i;
            arr_wdat_reg <= cpu_wdat_i;
        end
    end

    // ----------------------------------------
    // Burn sequence tracking
    // ----------------------------------------

    // Sequence state from control bits
    always_comb
    begin
        state_next = ebc_pkg::EBC_ST_IDLE;
        if (volt_next)
        begin
            state_next = ebc_pkg::EBC_ST_BURN;
        end
        else if (latch_next && captured_reg)
        begin
            state_next = ebc_pkg::EBC_ST_HELD;
        end
        else if (latch_next)
        begin
            state_next = ebc_pkg::EBC_ST_ARMED;
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= ebc_pkg::EBC_ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Times the voltage hold
    ebc_pulse_timer #(
        .CYCLES(BURN_PULSE_CYC)
    ) u_pulse (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(volt_reg),
        .done_o(pulse_done)
    );

    // ----------------------------------------
    // CPU side reads and loader ROM
    // ----------------------------------------

    // Boot ROM select only in bootloader mode
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            boot_sel_reg <= 1'b0;
        end
        else
        begin
            boot_sel_reg <= boot_mode_reg && in_boot;
        end
    end

    // Image source at the same address as the target
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_adr_reg <= '0;
            ext_rd_reg <= 1'b0;
        end
        else
        begin
            ext_adr_reg <= cpu_adr_i;
            ext_rd_reg <= boot_mode_reg && cpu_rd_i && in_eprom;
        end
    end

    // Read data: image once the source answers its address, blocked while latched
    always_ff @(posedge clk_i)
    begin
        if (rst_i || latch_reg)
        begin
            cpu_rdat_reg <= '0;
        end
        else if (ext_rd_reg)
        begin
            cpu_rdat_reg <= ext_rdat_i;
        end
        else
        begin
            cpu_rdat_reg <= arr_rdat_i;
        end
    end

    // ----------------------------------------
    // Indicator lamps
    // ----------------------------------------

    // Software lamp bits
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lamp_reg <= `EBC_LAMP_RST;
        end
        else if (wr_lamp)
        begin
            lamp_reg <= wb_dat_i[1:0];
        end
    end

    // Lamps lit only in bootloader mode
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            burn_lamp_reg <= 1'b0;
            check_lamp_reg <= 1'b0;
        end
        else
        begin
            burn_lamp_reg <= boot_mode_reg && lamp_reg[0];
            check_lamp_reg <= boot_mode_reg && lamp_reg[1];
        end
    end

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------

    // Ack one cycle after request, dropped next cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= wb_req;
        end
    end

    // Read mux, unmapped reads zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdat_reg <= '0;
        end
        else if (wb_req && !wb_we_i)
        begin
            unique case (wb_adr_i)
                `EBC_OFS_BURN: rdat_reg <= {29'h0, latch_reg, 1'b0, volt_reg};
                `EBC_OFS_STAT: rdat_reg <= {24'h0, state_reg, func_reg,
                    captured_reg, pulse_done, boot_mode_reg};
                `EBC_OFS_LAMP: rdat_reg <= {30'h0, lamp_reg};
                default: rdat_reg <= '0;
            endcase
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign wb_dat_o = rdat_reg;
    assign wb_ack_o = ack_reg;
    assign burn_indicator_pin_o = burn_lamp_reg;
    assign check_indicator_pin_o = check_lamp_reg;
    assign cpu_rdat_o = cpu_rdat_reg;
    assign boot_rom_sel_o = boot_sel_reg;
    assign arr_adr_o = arr_adr_reg;
    assign arr_wdat_o = arr_wdat_reg;
    assign arr_rd_en_o = rd_en_reg;
    assign ext_adr_o = ext_adr_reg;
    assign ext_rd_o = ext_rd_reg;

endmodule

// ==== verification/ebc_burn_ctl_props.sv ====
// Port checker for the burn control block
`timescale 1ns/1ps

module ebc_burn_ctl_props (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // Memory side
    input wire logic [13:0] cpu_adr_i,
    input wire logic [7:0] cpu_rdat_o,
    input wire logic boot_rom_sel_o,
    input wire logic arr_rd_en_o,
    input wire logic arr_vpp_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Burn register write taken, and a legal voltage request
    logic wr_burn;
    logic volt_req;
    assign wr_burn = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 4'h0
        && wb_sel_i[0];
    assign volt_req = wr_burn && wb_dat_i[0] && wb_dat_i[2] && !arr_rd_en_o;
    // ------------------------------
    // Assertions
    // ------------------------------
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_latch_sets: assert property (wr_burn && wb_dat_i[2] |=> !arr_rd_en_o)
        else $error("latch did not block reads");
    a_latch_clears: assert property (wr_burn && !wb_dat_i[2] |=> arr_rd_en_o && !arr_vpp_o)
        else $error("latch clear did not restore reads");
    a_volt_cause: assert property ($rose(arr_vpp_o) |-> $past(volt_req))
        else $error("voltage rose without latch");
    a_volt_sets: assert property (volt_req |=> arr_vpp_o)
        else $error("voltage not applied");
    a_no_double_set: assert property (wr_burn && arr_rd_en_o |=> !arr_vpp_o)
        else $error("voltage set together with latch");
    a_vpp_latched: assert property (arr_vpp_o |-> !arr_rd_en_o)
        else $error("voltage on with reads open");
    a_read_blocked: assert property (
        !arr_rd_en_o && !$past(arr_rd_en_o) |-> cpu_rdat_o == 8'h00)
        else $error("read data while latched");
    a_boot_rom_range: assert property (
        boot_rom_sel_o |-> $past(cpu_adr_i) inside {[14'h3f00:14'h3fef]})
        else $error("boot rom selected out of range");
    // Main scenarios
    c_volt: cover property ($rose(arr_vpp_o));
    c_rom: cover property (boot_rom_sel_o);
    c_read: cover property (wb_ack_o && !wb_we_i);
endmodule

bind ebc_burn_ctl ebc_burn_ctl_props chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .cpu_adr_i(cpu_adr_i), .cpu_rdat_o(cpu_rdat_o),
    .boot_rom_sel_o(boot_rom_sel_o), .arr_rd_en_o(arr_rd_en_o), .arr_vpp_o(arr_vpp_o));

// ==== verification/ebc_ext_image.sv ====
// Model of the external image source read by the loader
`timescale 1ns/1ps

module ebc_ext_image (
    // Clock
    input wire logic clk_i,
    // Loader access
    input wire logic [13:0] ext_adr_i,
    input wire logic ext_rd_i,
    output logic [7:0] ext_rdat_o
);
    logic [7:0] last_reg = 8'h00;
    // Byte kept at its destination address, released bus toggles
    always_comb
    begin
        ext_rdat_o = ext_rd_i ? ext_adr_i[7:0] ^ ext_adr_i[13:6] : ~last_reg;
    end
    // Last value on the bus
    always_ff @(posedge clk_i)
    begin
        last_reg <= ext_rdat_o;
    end
endmodule

// ==== verification/ebc_burn_ctl_tb.sv ====
// Self-checking bench for the burn control block
`timescale 1ns/1ps

module ebc_burn_ctl_tb;
    // Bench signals
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, tvl = 1'b0, cap = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0, rdat, seed = 32'h9b07;
    logic [2:0] fs = 3'h0;
    logic lamp_b, lamp_c, crd = 1'b0, cwr = 1'b0, brs, aren, vpp, erd;
    logic [13:0] cadr = 14'h0, aadr, eadr, a;
    logic [7:0] cwd = 8'h0, ardat = 8'h0, crdat, awd, erdat, d;
    logic [63:0] exp_q[$];
    logic [63:0] note;
    int fail_count = 0;
    int comparisons = 0;
    int i;

    always #10 clk_i = ~clk_i;

    ebc_burn_ctl #(.BURN_PULSE_CYC(20)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .test_voltage_level_i(tvl), .capture_input_pin_i(cap),
        .func_select_hi_i(fs[2]), .func_select_mid_i(fs[1]), .func_select_lo_i(fs[0]),
        .burn_indicator_pin_o(lamp_b), .check_indicator_pin_o(lamp_c), .cpu_adr_i(cadr),
        .cpu_rd_i(crd), .cpu_wr_i(cwr), .cpu_wdat_i(cwd), .cpu_rdat_o(crdat),
        .boot_rom_sel_o(brs), .arr_adr_o(aadr), .arr_wdat_o(awd), .arr_rd_en_o(aren),
        .arr_vpp_o(vpp), .arr_rdat_i(ardat), .ext_adr_o(eadr), .ext_rd_o(erd),
        .ext_rdat_i(erdat));
    ebc_ext_image src (.clk_i(clk_i), .ext_adr_i(eadr), .ext_rd_i(erd), .ext_rdat_o(erdat));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("Counts: %0d compared, %0d mismatched", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One classic bus cycle, held until ack
    task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] dt);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        dat <= dt;
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] ad, input logic [31:0] m, input logic [31:0] e);
        exp_q.push_back({m, e});
        wb(1'b0, ad, 32'h0);
    endtask

    // One memory access, outputs settled on return except read data from the image source, one cycle later
    task automatic cpu(input logic r, input logic [13:0] ad, input logic [7:0] dt);
        @(posedge clk_i);
        crd <= r;
        cwr <= !r;
        cadr <= ad;
        cwd <= dt;
        ardat <= dt ^ 8'h3c;
        @(posedge clk_i);
        crd <= 1'b0;
        cwr <= 1'b0;
        #1;
    endtask

    task automatic boot(input logic t, input logic c);
        @(posedge clk_i);
        rst_i <= 1'b1;
        tvl <= t;
        cap <= c;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    // Read data against the oldest note
    always @(posedge clk_i)
    begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
        begin
            note = exp_q.pop_front();
            check("read data", rdat & note[63:32], note[31:0]);
        end
    end

    // Main sequence
    initial
    begin
        boot(1'b1, 1'b0);
        rd(4'h4, 32'h1, 32'h0);
        rd(4'h0, 32'hff, 32'h0);
        rd(4'hc, 32'hffffffff, 32'h0);
        wb(1'b1, 4'h8, 32'h3);
        @(posedge clk_i);
        check("lamps", 32'({lamp_c, lamp_b}), 32'h0);
        wb(1'b1, 4'h0, 32'h1);
        rd(4'h0, 32'hff, 32'h0);
        wb(1'b1, 4'h0, 32'h5);
        rd(4'h0, 32'hff, 32'h4);
        check("vpp", 32'(vpp), 32'h0);
        $display("Test user mode done");
        seed = lfsr(seed);
        a = 14'h0020 + 14'(seed[12:0]);
        d = seed[20:13];
        cpu(1'b0, a, d);
        check("arr adr", 32'(aadr), 32'(a));
        check("arr data", 32'(awd), 32'(d));
        check("read en", 32'(aren), 32'h0);
        cpu(1'b0, a ^ 14'h1, ~d);
        check("arr adr", 32'(aadr), 32'(a));
        wb(1'b1, 4'h0, 32'h5);
        check("vpp", 32'(vpp), 32'h1);
        repeat (25) @(posedge clk_i);
        rd(4'h4, 32'h2, 32'h2);
        wb(1'b1, 4'h0, 32'h4);
        check("vpp", 32'(vpp), 32'h0);
        check("read en", 32'(aren), 32'h0);
        wb(1'b1, 4'h0, 32'h0);
        check("read en", 32'(aren), 32'h1);
        cpu(1'b1, a, d);
        check("arr adr", 32'(aadr), 32'(a));
        check("cpu data", 32'(crdat), 32'(d ^ 8'h3c));
        $display("Test burn done");
        boot(1'b1, 1'b1);
        rd(4'h4, 32'h1, 32'h1);
        for (i = 0; i < 8; i++)
        begin
            fs <= 3'(i);
            repeat (2) @(posedge clk_i);
            rd(4'h4, 32'h38, 32'(i > 3 ? 4 : i) << 3);
        end
        cpu(1'b1, 14'h3f00, 8'h0);
        check("rom sel", 32'(brs), 32'h1);
        cpu(1'b1, 14'h3fef, 8'h0);
        check("rom sel", 32'(brs), 32'h1);
        cpu(1'b1, 14'h3ff0, 8'h0);
        check("rom sel", 32'(brs), 32'h0);
        cpu(1'b1, a, d);
        check("src adr", 32'(eadr), 32'(a));
        check("src rd", 32'(erd), 32'h1);
        @(posedge clk_i);
        #1;
        check("src data", 32'(crdat), 32'(a[7:0] ^ a[13:6]));
        $display("Test boot mode done");
        for (i = 0; i < 4; i++)
        begin
            wb(1'b1, 4'h8, 32'(i));
            @(posedge clk_i);
            check("lamps", 32'({lamp_c, lamp_b}), 32'(i));
        end
        $display("Test lamps done");
        end_of_test();
    end

    // Watchdog
    initial
    begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        end_of_test();
    end
endmodule
